/* File: hw/rgbpk_pkg.sv */
// package for the rgb pixel byte packer link
// shared by the transmitter end and the panel unpacker end
package rgbpk_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned COMP_W      = 10;
  localparam int unsigned DEPTH8_W    = 8;
  // byte lane positions of the packer word
  localparam int unsigned RED_LSB     = 0;
  localparam int unsigned GREEN_LSB   = 8;
  localparam int unsigned BLUE_LSB    = 16;
  localparam int unsigned TOP_LSB     = 24;
  // two-bit low parts in the top byte
  localparam int unsigned BLUE_LO_LSB  = 26;
  localparam int unsigned GREEN_LO_LSB = 28;
  localparam int unsigned RED_LO_LSB   = 30;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [9:0]  COMP_RESET  = 10'h000;
  // depth select level: high selects 10-bit packing
  localparam logic        DEPTH_10BIT = 1'h1;

  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } rgbpk_pixel_t;
endpackage

/* File: hw/rgbpk_link_if.sv */
// link between the pixel transmitter and the panel unpacker
// one clock, word is sampled on the rising edge when valid is high
`timescale 1ns/1ps
`default_nettype none
interface rgbpk_link_if
(
  input wire logic ref_clk_i
);
  logic [31:0] word;
  logic        valid;
  logic        depth_10bit;

  modport tx
  (
    input  ref_clk_i,
    output word,
    output valid,
    output depth_10bit
  );

  modport rx
  (
    input  ref_clk_i,
    input  word,
    input  valid,
    input  depth_10bit
  );
endinterface
`default_nettype wire

/* File: hw/rgbpk_tx.sv */
// transmitter end: packs one rgb pixel into the 32-bit packer word
// assumes the panel supply state arrives synchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module rgbpk_tx
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  panel_supply_on_i,
  input  wire logic                  depth_10bit_i,
  input  wire logic                  pix_valid_i,
  input  wire rgbpk_pkg::rgbpk_pixel_t pix_i,
  rgbpk_link_if.tx                   link
);
  typedef struct packed {
    logic [31:0] word;
    logic        valid;
    logic        depth;
  } rgbpk_tx_state_t;

  rgbpk_tx_state_t state_reg;
  rgbpk_tx_state_t state_next;

  function automatic logic [31:0] rgbpk_pack(
    input logic                   d10,
    input rgbpk_pkg::rgbpk_pixel_t p
  );
    logic [31:0] w;
    w = rgbpk_pkg::WORD_RESET;
    if (d10)
    begin
      w[rgbpk_pkg::RED_LSB   +: 8] = p.red[9:2];
      w[rgbpk_pkg::GREEN_LSB +: 8] = p.green[9:2];
      w[rgbpk_pkg::BLUE_LSB  +: 8] = p.blue[9:2];
      w[rgbpk_pkg::BLUE_LO_LSB  +: 2] = p.blue[1:0];
      w[rgbpk_pkg::GREEN_LO_LSB +: 2] = p.green[1:0];
      w[rgbpk_pkg::RED_LO_LSB   +: 2] = p.red[1:0];
    end
    else
    begin
      w[rgbpk_pkg::RED_LSB   +: 8] = p.red[7:0];
      w[rgbpk_pkg::GREEN_LSB +: 8] = p.green[7:0];
      w[rgbpk_pkg::BLUE_LSB  +: 8] = p.blue[7:0];
    end
    return w;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    if (!panel_supply_on_i)
    begin
      // all lines held low while the panel is unpowered
      state_next.word  = rgbpk_pkg::WORD_RESET;
      state_next.valid = 1'b0;
      state_next.depth = 1'b0;
    end
    else
    begin
      state_next.depth = depth_10bit_i;
      state_next.valid = pix_valid_i;
      if (pix_valid_i)
      begin
        state_next.word = rgbpk_pack(depth_10bit_i, pix_i);
      end
      else
      begin
        state_next.word = rgbpk_pkg::WORD_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= '0;
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
    end
  end

  assign link.word        = state_reg.word;
  assign link.valid       = state_reg.valid;
  assign link.depth_10bit = state_reg.depth;
endmodule // rgbpk_tx
`default_nettype wire

/* File: hw/rgbpk_rx.sv */
// panel unpacker end: recovers rgb grey-level codes from the packer word
// assumes the transmitter keeps the link low while the panel is unpowered
//
// Notes on behaviour
// - 10-bit: bytes 0-2 carry colour bits 9:2
// - 10-bit: top byte holds low colour bits
// - 8-bit: bytes 0-2 carry full red, green, blue
// - larger code means brighter primary, unsigned
// - no link activity before panel supply on
// - lines driven low while supply is off
// - depth select high is 10-bit, low 8-bit
`timescale 1ns/1ps
`default_nettype none
module rgbpk_rx
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    clk_en_i,
  rgbpk_link_if.rx                     link,
  output var  logic                    pix_valid_o,
  output var  rgbpk_pkg::rgbpk_pixel_t pix_o
);
  typedef struct packed {
    rgbpk_pkg::rgbpk_pixel_t pix;
    logic                    valid;
  } rgbpk_rx_state_t;

  rgbpk_rx_state_t state_reg;
  rgbpk_rx_state_t state_next;

  function automatic logic [9:0] rgbpk_comp(
    input logic       d10,
    input logic [7:0] hi,
    input logic [1:0] lo
  );
    // unsigned code, 8-bit values sit in the low bits
    if (d10)
    begin
      return {hi, lo};
    end
    return {2'h0, hi};
  endfunction

  always_comb
  begin
    state_next = state_reg;
    state_next.valid = link.valid;
    if (link.valid)
    begin
      // top byte bits 24-25 are ignored
      state_next.pix.red = rgbpk_comp(link.depth_10bit,
        link.word[rgbpk_pkg::RED_LSB +: 8],
        link.word[rgbpk_pkg::RED_LO_LSB +: 2]);
      state_next.pix.green = rgbpk_comp(link.depth_10bit,
        link.word[rgbpk_pkg::GREEN_LSB +: 8],
        link.word[rgbpk_pkg::GREEN_LO_LSB +: 2]);
      state_next.pix.blue = rgbpk_comp(link.depth_10bit,
        link.word[rgbpk_pkg::BLUE_LSB +: 8],
        link.word[rgbpk_pkg::BLUE_LO_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= '0;
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
    end
  end

  assign pix_valid_o = state_reg.valid;
  assign pix_o       = state_reg.pix;
endmodule // rgbpk_rx
`default_nettype wire

/* File: verif/rgbpk_monitor.sv */
// link checker for the rgb packer interface
// sees link signals, reset and the panel supply level
`timescale 1ns/1ps
`default_nettype none
module rgbpk_monitor
(
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        panel_supply_on_i,
  input wire logic [31:0] word,
  input wire logic        valid,
  input wire logic        depth_10bit
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_idle; !valid |-> word == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle word");
  property p_top8; valid && !depth_10bit |-> word[31:24] == 8'h0;
  endproperty
  a_top8: assert property (p_top8) else $error("top byte");
  property p_pad; valid && depth_10bit |-> word[25:24] == 2'h0; endproperty
  a_pad: assert property (p_pad) else $error("pad bits");
  property p_rst; $fell(reset_i) |-> !valid; endproperty
  a_rst: assert property (p_rst) else $error("valid at reset");
  property p_rdep; $fell(reset_i) |-> !depth_10bit; endproperty
  a_rdep: assert property (p_rdep) else $error("depth at reset");
  property p_off; !$past(panel_supply_on_i) |-> !valid && !depth_10bit;
  endproperty
  a_off: assert property (p_off) else $error("link on, supply off");
  property p_on; valid |-> $past(panel_supply_on_i); endproperty
  a_on: assert property (p_on) else $error("early word");
  property p_run; !panel_supply_on_i [*2] |=> word == 32'h0; endproperty
  a_run: assert property (p_run) else $error("word, supply off");
endmodule // rgbpk_monitor
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench: transmitter and unpacker joined by the link
// random pixels, depths and supply levels from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sup = 1'b0;
  logic d10 = 1'b0;
  logic pv = 1'b0;
  rgbpk_pkg::rgbpk_pixel_t p = '0;
  rgbpk_pkg::rgbpk_pixel_t po;
  logic pvo;
  logic [31:0] qw[$];
  logic [31:0] qp[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  rgbpk_link_if link (.ref_clk_i(ref_clk_i));
  rgbpk_tx i_rgbpk_tx (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .clk_en_i(1'b1), .panel_supply_on_i(sup), .depth_10bit_i(d10),
    .pix_valid_i(pv), .pix_i(p), .link(link));
  rgbpk_rx i_rgbpk_rx (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .clk_en_i(1'b1), .link(link), .pix_valid_o(pvo), .pix_o(po));
  rgbpk_monitor i_rgbpk_monitor (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .panel_supply_on_i(sup), .word(link.word), .valid(link.valid),
    .depth_10bit(link.depth_10bit));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      stop_test();
    end
    if (!reset_i && link.valid)
      chk(link.word, qw.pop_front());
    if (!reset_i && pvo)
      chk({2'h0, po}, qp.pop_front());
  end
  initial
  begin
    void'($urandom(68));
    repeat (6) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge ref_clk_i);
      #1;
      sup = i >= 20 && $urandom % 8 != 0;
      d10 = 1'($urandom);
      pv = 1'($urandom);
      p = rgbpk_pkg::rgbpk_pixel_t'(30'($urandom));
      if (sup && pv)
      begin
        qw.push_back(d10 ? {p.red[1:0], p.green[1:0], p.blue[1:0], 2'h0,
          p.blue[9:2], p.green[9:2], p.red[9:2]} :
          {8'h0, p.blue[7:0], p.green[7:0], p.red[7:0]});
        qp.push_back(d10 ? {2'h0, p} : {4'h0, p.red[7:0], 2'h0,
          p.green[7:0], 2'h0, p.blue[7:0]});
      end
    end
    @(posedge ref_clk_i);
    #1 pv = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk(qw.size() + qp.size(), 32'h0);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
